// File: rtl/ldma_pkg.sv
// shared constants and types for the seven channel dma engine
package ldma_pkg;
    localparam int NCH = 8;
    localparam logic [2:0] CH_BM = 3'h4;
    localparam logic [2:0] CH_LAST_BYTE = 3'h3;
    localparam int MAX_FAST = 2;
    // save/restore port field selects
    localparam logic [2:0] F_BADDR = 3'h0;
    localparam logic [2:0] F_CADDR = 3'h1;
    localparam logic [2:0] F_BCNT = 3'h2;
    localparam logic [2:0] F_CCNT = 3'h3;
    localparam logic [2:0] F_MODE = 3'h4;
    localparam logic [2:0] F_MASK = 3'h5;
    localparam logic [2:0] F_FAST = 3'h6;
    localparam logic [2:0] F_STAT = 3'h7;
    // mode field layout
    localparam int M_XFER_LSB = 0;
    localparam int M_AUTO = 2;
    localparam int M_DEC = 3;
    localparam int M_SVC_LSB = 4;
    localparam logic [1:0] XFER_VERIFY = 2'h0;
    localparam logic [1:0] XFER_WRITE = 2'h1;
    localparam logic [1:0] XFER_READ = 2'h2;
    localparam logic [1:0] SVC_DEMAND = 2'h0;
    localparam logic [1:0] SVC_SINGLE = 2'h1;
    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [5:0] RST_MODE = 6'h00;
    localparam logic [7:0] RST_MASK = 8'hff;
    localparam logic [7:0] RST_FAST = 8'h00;
    // link nibble codes
    localparam logic [3:0] LAD_START = 4'h0;
    localparam logic [3:0] CT_DMA_RD = 4'h8;
    localparam logic [3:0] CT_DMA_WR = 4'ha;
    localparam logic [3:0] SIZE_BYTE = 4'h0;
    localparam logic [3:0] SIZE_WORD = 4'h1;
    localparam logic [3:0] SYNC_READY = 4'h0;
    localparam logic [3:0] SYNC_ERR = 4'ha;
    localparam logic [3:0] LAD_IDLE = 4'hf;
    // request source per channel
    localparam logic [1:0] SRC_LINK = 2'h0;
    localparam logic [1:0] SRC_PAIR0 = 2'h1;
    localparam logic [1:0] SRC_PAIR1 = 2'h2;
    // serial request frame: start + 3 channel bits + active bit
    localparam logic [2:0] RQ_BITS = 3'h4;

    typedef enum logic [7:0] {
        ST_IDLE = 8'b0000_0001,
        ST_START = 8'b0000_0010,
        ST_CTYPE = 8'b0000_0100,
        ST_CHAN = 8'b0000_1000,
        ST_SIZE = 8'b0001_0000,
        ST_TAR = 8'b0010_0000,
        ST_SYNC = 8'b0100_0000,
        ST_DONE = 8'b1000_0000
    } ldma_state_t;
endpackage : ldma_pkg

// File: rtl/ldma_rqrx.sv
// serial dma request receiver with pin synchroniser
`timescale 1ns/1ps
module ldma_rqrx (
    input wire logic sys_clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic rq_pin_b, // serial request pin, active low start
    output logic rq_vld, // one-cycle pulse, frame received
    output logic [2:0] rq_ch, // requested channel
    output logic rq_act // request active (1) or withdrawn (0)
);
    import ldma_pkg::*;
    logic sync1_r, sync2_r;
    logic busy_r;
    logic [2:0] cnt_r;
    logic [3:0] sh_r;
    logic vld_r;

    assign rq_vld = vld_r;
    assign rq_ch = sh_r[3:1];
    assign rq_act = sh_r[0];

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= rq_pin_b;
            sync2_r <= sync1_r;
        end
    end

    // frame: low start bit, channel msb first, then active bit
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_r <= 1'b0;
            cnt_r <= 3'h0;
            sh_r <= 4'h0;
            vld_r <= 1'b0;
        end else begin
            vld_r <= busy_r && (cnt_r == RQ_BITS - 3'h1);
            if (!busy_r) begin
                busy_r <= !sync2_r;
                cnt_r <= 3'h0;
            end else begin
                sh_r <= {sh_r[2:0], sync2_r};
                cnt_r <= cnt_r + 3'h1;
                busy_r <= (cnt_r != RQ_BITS - 3'h1);
            end
        end
    end
endmodule : ldma_rqrx

// File: rtl/ldma_top.sv
// seven channel dma engine serving link and sideband pair requests
`timescale 1ns/1ps
module ldma_top (
    input wire logic sys_clk, // 20 MHz system clock
    input wire logic rst_b, // async reset, active low
    input wire logic cfg_we, // save/restore write strobe
    input wire logic [2:0] cfg_ch, // channel index
    input wire logic [2:0] cfg_sel, // field select
    input wire logic [15:0] cfg_wdata, // write data
    output logic [15:0] cfg_rdata, // read data, registered
    input wire logic ldrq_b, // link dma request pin
    input wire logic [1:0] sb_req_b, // sideband request pins
    output logic [1:0] sb_gnt_b, // sideband grant pins
    input wire logic [3:0] lad_in, // link nibble in
    output logic [3:0] lad_out, // link nibble out
    output logic lad_oe_b, // link drive enable, low drives
    output logic lframe_b, // link frame, active low
    output logic bm_req, // bus-master request on channel four
    output logic [15:0] dma_addr, // address of the last completed transfer, registered
    output logic dma_word, // current transfer is word wide
    output logic dma_tc // terminal count pulse, registered
);
    import ldma_pkg::*;

    logic [15:0] baddr_r [NCH];
    logic [15:0] caddr_r [NCH];
    logic [15:0] bcnt_r [NCH];
    logic [15:0] ccnt_r [NCH];
    logic [5:0] mode_r [NCH];
    logic [7:0] mask_r, fast_r, req_r, tc_r;
    logic [1:0] src_r [NCH];
    ldma_state_t st_r, st_nxt;
    logic [2:0] ch_r;
    logic err_r, tc_pulse_r;
    logic [15:0] rdata_r, addr_r;
    logic [3:0] sy1_r, sy2_r;
    logic [3:0] gsh_r [2];
    logic [3:0] lad_r;
    logic oe_b_r, frame_b_r;

    logic [2:0] rx_ch [3];
    logic rx_vld [3];
    logic rx_act [3];

    function automatic logic [2:0] pick_low(input logic [7:0] v);
        pick_low = 3'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                pick_low = 3'(i);
            end
        end
    endfunction : pick_low

    function automatic logic [15:0] step_addr(input logic [15:0] a, input logic dec);
        step_addr = dec ? a - 16'h1 : a + 16'h1;
    endfunction : step_addr

    ldma_rqrx u_rx_link (.sys_clk(sys_clk), .rst_b(rst_b), .rq_pin_b(ldrq_b),
        .rq_vld(rx_vld[0]), .rq_ch(rx_ch[0]), .rq_act(rx_act[0]));
    ldma_rqrx u_rx_p0 (.sys_clk(sys_clk), .rst_b(rst_b), .rq_pin_b(sb_req_b[0]),
        .rq_vld(rx_vld[1]), .rq_ch(rx_ch[1]), .rq_act(rx_act[1]));
    ldma_rqrx u_rx_p1 (.sys_clk(sys_clk), .rst_b(rst_b), .rq_pin_b(sb_req_b[1]),
        .rq_vld(rx_vld[2]), .rq_ch(rx_ch[2]), .rq_act(rx_act[2]));

    // both request paths feed one pending vector and one arbiter
    wire [7:0] pend = req_r & ~mask_r & ~(8'h1 << CH_BM);
    wire go = (st_r == ST_IDLE) && (pend != 8'h0);
    wire [2:0] go_ch = pick_low(pend);
    wire is_word = (ch_r > CH_BM);
    wire [1:0] xfer = mode_r[ch_r][M_XFER_LSB +: 2];
    wire [1:0] svc = mode_r[ch_r][M_SVC_LSB +: 2];
    wire last = (ccnt_r[ch_r] == 16'h0);
    wire done_ok = (st_r == ST_DONE) && !err_r;
    wire fast_ch = fast_r[ch_r];
    wire cfg_fast = cfg_we && (cfg_sel == F_FAST);
    // a fast selection naming more than two channels other than channel four is refused
    wire fast_ok = ($countones(cfg_wdata[7:0] & ~(8'h1 << CH_BM)) <= MAX_FAST);
    wire [15:0] sel_ccnt = ccnt_r[ch_r];

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE: st_nxt = go ? ST_START : ST_IDLE;
            ST_START: st_nxt = ST_CTYPE;
            ST_CTYPE: st_nxt = ST_CHAN;
            ST_CHAN: st_nxt = ST_SIZE;
            ST_SIZE: st_nxt = fast_ch ? ST_SYNC : ST_TAR;
            ST_TAR: st_nxt = ST_SYNC;
            ST_SYNC: st_nxt = (sy2_r == SYNC_READY || sy2_r == SYNC_ERR) ? ST_DONE : ST_SYNC;
            ST_DONE: st_nxt = ST_IDLE;
        endcase
    end

    // nibble driven in each phase; verify still walks the cycle, no data
    logic [3:0] lad_nxt;
    always_comb begin
        lad_nxt = LAD_IDLE;
        unique case (st_nxt)
            ST_START: lad_nxt = LAD_START;
            ST_CTYPE: lad_nxt = (xfer == XFER_READ) ? CT_DMA_RD : CT_DMA_WR;
            ST_CHAN: lad_nxt = {last, ch_r};
            ST_SIZE: lad_nxt = is_word ? SIZE_WORD : SIZE_BYTE;
            default: lad_nxt = LAD_IDLE;
        endcase
    end

    wire drive_nxt = (st_nxt == ST_START) || (st_nxt == ST_CTYPE) || (st_nxt == ST_CHAN) || (st_nxt == ST_SIZE);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= ST_IDLE;
            ch_r <= 3'h0;
            err_r <= 1'b0;
            sy1_r <= LAD_IDLE;
            sy2_r <= LAD_IDLE;
            lad_r <= LAD_IDLE;
            oe_b_r <= 1'b1;
            frame_b_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            sy1_r <= lad_in;
            sy2_r <= sy1_r;
            lad_r <= lad_nxt;
            oe_b_r <= !drive_nxt;
            frame_b_r <= (st_nxt != ST_START);
            if (go) begin
                ch_r <= go_ch;
            end
            if (st_r == ST_SYNC) begin
                err_r <= (sy2_r == SYNC_ERR);
            end
        end
    end

    // grant goes back on the pair that carried the request: low start + channel
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gsh_r[0] <= 4'hf;
            gsh_r[1] <= 4'hf;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (go && (src_r[go_ch] == 2'(p + 1))) begin
                    gsh_r[p] <= {1'b0, go_ch};
                end else begin
                    gsh_r[p] <= {gsh_r[p][2:0], 1'b1};
                end
            end
        end
    end

    // per channel state; save/restore writes take priority over engine updates except the terminal count flag set
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int c = 0; c < NCH; c++) begin
                baddr_r[c] <= RST_WORD;
                caddr_r[c] <= RST_WORD;
                bcnt_r[c] <= RST_WORD;
                ccnt_r[c] <= RST_WORD;
                mode_r[c] <= RST_MODE;
                src_r[c] <= SRC_LINK;
            end
            mask_r <= RST_MASK;
            fast_r <= RST_FAST;
            req_r <= 8'h00;
            tc_r <= 8'h00;
            tc_pulse_r <= 1'b0;
            addr_r <= RST_WORD;
            rdata_r <= RST_WORD;
        end else begin
            tc_pulse_r <= done_ok && last;
            if (done_ok) begin
                addr_r <= caddr_r[ch_r];
                // count one unit per transfer: byte on low, word on high channels
                ccnt_r[ch_r] <= last && mode_r[ch_r][M_AUTO] ? bcnt_r[ch_r] : ccnt_r[ch_r] - 16'h1;
                caddr_r[ch_r] <= last && mode_r[ch_r][M_AUTO] ? baddr_r[ch_r] :
                    step_addr(caddr_r[ch_r], mode_r[ch_r][M_DEC]);
                if (last && !mode_r[ch_r][M_AUTO]) begin
                    mask_r[ch_r] <= 1'b1;
                end
                if (svc == SVC_SINGLE || last) begin
                    req_r[ch_r] <= 1'b0;
                end
            end
            for (int s = 0; s < 3; s++) begin
                if (rx_vld[s]) begin
                    req_r[rx_ch[s]] <= rx_act[s];
                    src_r[rx_ch[s]] <= 2'(s);
                end
            end
            if (cfg_we) begin
                unique case (cfg_sel)
                    F_BADDR: baddr_r[cfg_ch] <= cfg_wdata;
                    F_CADDR: caddr_r[cfg_ch] <= cfg_wdata;
                    F_BCNT: bcnt_r[cfg_ch] <= cfg_wdata;
                    F_CCNT: ccnt_r[cfg_ch] <= cfg_wdata;
                    F_MODE: mode_r[cfg_ch] <= cfg_wdata[5:0];
                    F_MASK: mask_r <= cfg_wdata[7:0];
                    F_FAST: fast_r <= fast_ok ? cfg_wdata[7:0] & ~(8'h1 << CH_BM) : fast_r;
                    F_STAT: tc_r <= cfg_wdata[7:0];
                endcase
            end
            // terminal count flag set wins over a same-cycle restore
            if (done_ok && last) begin
                tc_r[ch_r] <= 1'b1;
            end
            unique case (cfg_sel)
                F_BADDR: rdata_r <= baddr_r[cfg_ch];
                F_CADDR: rdata_r <= caddr_r[cfg_ch];
                F_BCNT: rdata_r <= bcnt_r[cfg_ch];
                F_CCNT: rdata_r <= ccnt_r[cfg_ch];
                F_MODE: rdata_r <= {10'h000, mode_r[cfg_ch]};
                F_MASK: rdata_r <= {8'h00, mask_r};
                F_FAST: rdata_r <= {8'h00, fast_r};
                F_STAT: rdata_r <= {req_r, tc_r};
            endcase
        end
    end

    assign cfg_rdata = rdata_r;
    assign lad_out = lad_r;
    assign lad_oe_b = oe_b_r;
    assign lframe_b = frame_b_r;
    assign sb_gnt_b = {gsh_r[1][3], gsh_r[0][3]};
    assign bm_req = req_r[CH_BM];
    assign dma_addr = addr_r;
    assign dma_word = is_word && (st_r != ST_IDLE);
    assign dma_tc = tc_pulse_r;

    AST_BYTE_SIZE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (st_r == ST_SIZE) && (ch_r <= CH_LAST_BYTE) |-> (lad_out == SIZE_BYTE) && !lad_oe_b)
        else $error("byte channel sent wrong size");
    AST_WORD_SIZE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (st_r == ST_SIZE) && (ch_r > CH_BM) |-> (lad_out == SIZE_WORD))
        else $error("word channel sent wrong size");
    AST_FAST_LIMIT: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $countones(fast_r) <= MAX_FAST)
        else $error("more than two fast channels");
    AST_BM_NO_XFER: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (st_r != ST_IDLE) |-> (ch_r != CH_BM))
        else $error("channel four ran a transfer");
    AST_COUNT_STEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
        done_ok && !last && !(cfg_we && cfg_sel == F_CCNT) |=> sel_ccnt == $past(sel_ccnt) - 16'h1)
        else $error("count did not step by one");
    AST_LINK_START: assert property (@(posedge sys_clk) disable iff (!rst_b)
        go |=> !lframe_b && !lad_oe_b && (lad_out == LAD_START) ##1 lframe_b ##2 (st_r == ST_SIZE))
        else $error("link cycle start sequence wrong");
    AST_PAIR_GRANT: assert property (@(posedge sys_clk) disable iff (!rst_b)
        go && (src_r[go_ch] == SRC_PAIR1) |=> !sb_gnt_b[1] ##1 (sb_gnt_b[1] == ch_r[2]))
        else $error("grant not returned on pair");
    AST_RESTORE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cfg_we && (cfg_sel == F_BCNT) ##1 (cfg_sel == F_BCNT) && (cfg_ch == $past(cfg_ch)) && !cfg_we
        |=> cfg_rdata == $past(cfg_wdata, 2))
        else $error("restored value not read back");
    COV_WORD_XFER: cover property (@(posedge sys_clk) disable iff (!rst_b) done_ok && is_word);
    COV_TC: cover property (@(posedge sys_clk) disable iff (!rst_b) dma_tc);
    COV_PAIR0: cover property (@(posedge sys_clk) disable iff (!rst_b) go && src_r[go_ch] == SRC_PAIR0);
endmodule : ldma_top

// File: verification/ldma_peer.sv
// far-side peripheral model: serial request frames and sync replies
`timescale 1ns/1ps
module ldma_peer
    import ldma_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic lad_oe_b, // engine drive enable, low drives
    input wire logic lframe_b, // frame start from engine
    output logic ldrq_b, // link request pin
    output logic [1:0] sb_req_b, // sideband request pins
    output logic [3:0] lad_in // nibble back to engine
);
    int wait_n = 1;
    // one-shot reply code, falls back to ready after each use
    logic [3:0] sync_code = SYNC_READY;
    initial begin
        ldrq_b = 1'b1;
        sb_req_b = 2'h3;
        lad_in = 4'hf;
    end
    // start bit, channel msb first, active bit, then line back high
    task automatic send_rq(input int src, input logic [2:0] ch, input logic act);
        logic [5:0] fr;
        fr = {1'b0, ch, act, 1'b1};
        for (int i = 5; i >= 0; i--) begin
            @(posedge sys_clk);
            #1;
            if (src == 0) ldrq_b = fr[i];
            else sb_req_b[src - 1] = fr[i];
        end
    endtask : send_rq
    // sync held two cycles so the engine's input flops cannot miss it
    initial begin
        forever begin
            @(posedge sys_clk);
            #1;
            if (lframe_b === 1'b0) begin
                for (int k = 0; k < 20 && lad_oe_b !== 1'b1; k++) begin
                    @(posedge sys_clk);
                    #1;
                end
                repeat (wait_n) begin
                    @(posedge sys_clk);
                    #1;
                end
                lad_in = sync_code;
                sync_code = SYNC_READY;
                repeat (2) @(posedge sys_clk);
                #1;
                // released lines float up to the pull-up level
                lad_in = 4'hf;
            end
        end
    end
endmodule : ldma_peer

// File: verification/tb.sv
// self-checking bench for the seven channel dma engine
`timescale 1ns/1ps
module tb;
    import ldma_pkg::*;
    logic sys_clk, rst_b, cfg_we, ldrq_b, lad_oe_b, lframe_b, bm_req, dma_word, dma_tc;
    logic [2:0] cfg_ch, cfg_sel;
    logic [15:0] cfg_wdata, cfg_rdata, dma_addr, rv;
    logic [1:0] sb_req_b, sb_gnt_b;
    logic [3:0] lad_in, lad_out;
    logic [15:0] ref_f [8][5];
    logic [7:0] ref_mask = 8'hff;
    int fails = 0;
    int n_tests = 0;
    int n_tc = 0;
    int n_fr = 0;
    int us [7] = '{0, 1, 2, 3, 5, 6, 7};
    int cs [6] = '{0, 1, 3, 5, 6, 7};

    ldma_top i_ldma_top (.sys_clk(sys_clk), .rst_b(rst_b), .cfg_we(cfg_we), .cfg_ch(cfg_ch),
        .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .ldrq_b(ldrq_b),
        .sb_req_b(sb_req_b), .sb_gnt_b(sb_gnt_b), .lad_in(lad_in), .lad_out(lad_out),
        .lad_oe_b(lad_oe_b), .lframe_b(lframe_b), .bm_req(bm_req), .dma_addr(dma_addr),
        .dma_word(dma_word), .dma_tc(dma_tc));
    ldma_peer i_ldma_peer (.sys_clk(sys_clk), .lad_oe_b(lad_oe_b), .lframe_b(lframe_b),
        .ldrq_b(ldrq_b), .sb_req_b(sb_req_b), .lad_in(lad_in));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (dma_tc === 1'b1) n_tc++;
        if (lframe_b === 1'b0) n_fr++;
    end
    initial begin
        #5000000;
        fails++;
        report_and_stop();
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // write strobe dropped a cycle early so back-to-back calls never collide
    task automatic wr(input logic [2:0] sel, input logic [2:0] ch, input logic [15:0] d);
        cfg_we = 1'b1;
        cfg_sel = sel;
        cfg_ch = ch;
        cfg_wdata = d;
        @(posedge sys_clk);
        #1;
        cfg_we = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [2:0] sel, input logic [2:0] ch, output logic [15:0] v);
        cfg_sel = sel;
        cfg_ch = ch;
        repeat (2) @(posedge sys_clk);
        #1;
        v = cfg_rdata;
    endtask : rd
    task automatic wait_fr;
        bit ok;
        ok = 1'b0;
        for (int k = 0; k < 60 && !ok; k++) begin
            @(posedge sys_clk);
            #1;
            ok = (lframe_b === 1'b0);
        end
        if (!ok) begin
            fails++;
            $display("ERROR lframe_b expected 0 seen 1");
            report_and_stop();
        end
    endtask : wait_fr
    task automatic run_case(input int i);
        logic [2:0] ch;
        logic [1:0] xf;
        logic [15:0] a, last, nib;
        int src, nx, t0, f0;
        bit dec, ai;
        ch = 3'(cs[i]);
        src = i % 3;
        nx = i % 2;
        xf = 2'((i + 1) % 3);
        dec = ((i / 2) % 2) == 1;
        ai = (i == 5);
        a = 16'($urandom);
        last = a;
        wr(F_CADDR, ch, a);
        wr(F_CCNT, ch, 16'(nx));
        wr(F_MODE, ch, {10'h000, (nx == 1) ? SVC_DEMAND : SVC_SINGLE, dec, ai, xf});
        ref_mask[ch] = 1'b0;
        wr(F_MASK, 3'h0, {8'h00, ref_mask});
        i_ldma_peer.wait_n = $urandom_range(0, 4);
        // first case answers its first cycle with an error, so the engine must retry
        i_ldma_peer.sync_code = (i == 0) ? SYNC_ERR : SYNC_READY;
        t0 = n_tc;
        f0 = n_fr;
        i_ldma_peer.send_rq(src, ch, 1'b1);
        for (int n = 0; n <= nx; n++) begin
            wait_fr();
            nib = {LAD_START, (xf == XFER_READ) ? CT_DMA_RD : CT_DMA_WR, n == nx, ch,
                (ch > 3'h4) ? SIZE_WORD : SIZE_BYTE};
            for (int k = 0; k < 4; k++) begin
                if (k > 0) begin
                    @(posedge sys_clk);
                    #1;
                end
                chk("lad", 16'(nib[15 - 4 * k -: 4]), {11'h000, lad_oe_b, lad_out});
                if (src > 0) chk("sb_gnt_b", 16'((k == 0) ? 1'b0 : ch[3 - k]), 16'(sb_gnt_b[src - 1]));
            end
            chk("dma_word", 16'(ch > 3'h4), 16'(dma_word));
            last = a;
            a = dec ? a - 16'h0001 : a + 16'h0001;
        end
        repeat (40) @(posedge sys_clk);
        #1;
        chk("frames", 16'(nx + 1 + ((i == 0) ? 1 : 0)), 16'(n_fr - f0));
        chk("tc pulses", 16'h0001, 16'(n_tc - t0));
        chk("dma_addr", last, dma_addr);
        rd(F_CADDR, ch, rv);
        chk("cur addr", ai ? ref_f[ch][0] : a, rv);
        rd(F_STAT, 3'h0, rv);
        chk("stat", 16'h0001, 16'({rv[8 + ch], rv[ch]}));
        rd(F_MASK, 3'h0, rv);
        ref_mask[ch] = ~ai;
        chk("mask", {8'h00, ref_mask}, rv);
        $display("done transfer case %0d", i);
    endtask : run_case

    initial begin
        int p, u;
        rst_b = 1'b0;
        cfg_we = 1'b0;
        cfg_ch = 3'h0;
        cfg_sel = 3'h0;
        cfg_wdata = 16'h0000;
        void'($urandom(79));
        repeat (8) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        chk("idle pins", 16'h07f8, {5'h00, lad_out, lad_oe_b, lframe_b, sb_gnt_b, bm_req, dma_word, dma_tc});
        chk("cfg_rdata", RST_WORD, cfg_rdata);
        chk("dma_addr", RST_WORD, dma_addr);
        rd(F_MASK, 3'h0, rv);
        chk("mask", {8'h00, RST_MASK}, rv);
        rd(F_FAST, 3'h0, rv);
        chk("fast", {8'h00, RST_FAST}, rv);
        rd(F_MODE, 3'h6, rv);
        chk("mode", {10'h000, RST_MODE}, rv);
        $display("done reset values");
        for (int c = 0; c < NCH; c++) begin
            for (int s = 0; s < 5; s++) begin
                ref_f[c][s] = (s == 4) ? 16'($urandom_range(0, 63)) : 16'($urandom);
                wr(3'(s), 3'(c), ref_f[c][s]);
            end
        end
        for (int c = 0; c < NCH; c++) begin
            for (int s = 0; s < 5; s++) begin
                rd(3'(s), 3'(c), rv);
                chk("channel field", ref_f[c][s], rv);
            end
        end
        wr(F_STAT, 3'h0, 16'h00a5);
        rd(F_STAT, 3'h0, rv);
        chk("stat", 16'h00a5, rv);
        wr(F_STAT, 3'h0, 16'h0000);
        $display("done save and restore");
        for (int k = 0; k < 4; k++) begin
            u = $urandom_range(0, 6);
            p = (1 << us[u]) | (1 << us[(u + 1 + $urandom_range(0, 5)) % 7]);
            wr(F_FAST, 3'h0, 16'(p));
            rd(F_FAST, 3'h0, rv);
            chk("fast pair", 16'(p), rv);
            wr(F_FAST, 3'h0, 16'h00ef);
            rd(F_FAST, 3'h0, rv);
            chk("fast refused", 16'(p), rv);
        end
        // channels 0 and 5 ride the short timing during the transfers
        wr(F_FAST, 3'h0, 16'h0021);
        $display("done fast selection");
        for (int i = 0; i < 6; i++) run_case(i);
        ref_mask[4] = 1'b0;
        wr(F_MASK, 3'h0, {8'h00, ref_mask});
        p = n_fr;
        i_ldma_peer.send_rq(0, CH_BM, 1'b1);
        repeat (10) @(posedge sys_clk);
        #1;
        chk("bm_req", 16'h0001, 16'(bm_req));
        i_ldma_peer.send_rq(0, CH_BM, 1'b0);
        repeat (10) @(posedge sys_clk);
        #1;
        chk("bm_req", 16'h0000, 16'(bm_req));
        chk("frames", 16'h0000, 16'(n_fr - p));
        $display("done bus-master channel");
        report_and_stop();
    end
endmodule : tb
